// ### src/oisa_alu.sv
/*
  Execution slice for five byte instructions: or-immediate, increment,
  or-with-register and logical shifts, with accumulator and flags.
  Assumes the decoder issues one op per clock with the register operand
  already read from the register file on the same clock domain.
  Unlisted op codes are ignored, and the register file itself must
  resolve read-after-write, as nothing is forwarded here.
*/
// How it works
// (RL1) Or-immediate ORs the 8-bit literal into the accumulator and updates only the zero flag.
// (RL2) Increment adds one to the addressed register, sends it to the destination, zero only.
// (RL3) Or-with-register ORs the accumulator with the register, to destination, zero only.
// (RL4) The destination select bit sends register-operand results to acc (0) or register (1).
// (RL5) Left shift moves bit 7 to shift-out, bits 6:0 up, zero in, updating carry and zero.
// (RL6) Right shift moves bit 0 to shift-out, bits 7:1 down, zero in, updating carry and zero.
// (RL7) The zero flag is set on an all-zero result and cleared otherwise.
// (RL8) Each op completes in one cycle and flags not named keep their value.
`timescale 1ns/100ps
module oisa_alu #(
  parameter int DW = oisa_pkg::OISA_DATA_W,
  parameter int AW = oisa_pkg::OISA_ADDR_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Decoded instruction
  input wire logic op_valid,
  input wire oisa_pkg::oisa_op_t op_code,
  input wire logic [DW-1:0] immediate_literal,
  input wire logic [AW-1:0] register_operand_address,
  input wire logic result_target_bit,
  // Register file read data for the addressed register
  input wire logic [DW-1:0] reg_rd_data,
  // Register file write-back
  output logic reg_wr_en,
  output logic [AW-1:0] reg_wr_addr,
  output logic [DW-1:0] reg_wr_data,
  // Architectural state
  output logic [DW-1:0] acc_q,
  output logic null_result_flag,
  output logic shift_out_bit,
  output logic op_done
);
  import oisa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Internal nets

  // Result unit outputs
  logic [DW-1:0] res;
  logic res_zero;
  logic res_carry;

  // Op class from the first decode table
  logic op_ok;
  logic op_acc_only;
  logic op_reg_src;

  // Flag effects from the second decode table
  logic hit_zero;
  logic hit_carry;

  // Issue qualifier and destination steering
  logic issue;
  logic to_reg;
  logic to_acc;

  ////////////////////////////////////////////////////////////////////////
  // Result computation

  // One combinational unit shared by all five ops
  oisa_op_unit #(
    .DW(DW)
  ) u_op (
    .op(op_code),
    .acc_val(acc_q),
    .reg_val(reg_rd_data),
    .imm_val(immediate_literal),
    .result(res),
    .is_zero(res_zero),
    .shift_out(res_carry)
  );

  ////////////////////////////////////////////////////////////////////////
  // Instruction decode

  // Operand source per op; unlisted codes decode as no operation
  always_comb begin
    op_ok = 1'b0;
    op_acc_only = 1'b0;
    op_reg_src = 1'b0;
    case (op_code)
      OISA_OP_OR_IMMEDIATE_INTO_ACC: begin
        op_ok = 1'b1;
        op_acc_only = 1'b1; // [RL1]
      end
      OISA_OP_REGISTER_INCREMENT: begin
        op_ok = 1'b1;
        op_reg_src = 1'b1; // [RL2]
      end
      OISA_OP_OR_ACC_WITH_REGISTER: begin
        op_ok = 1'b1;
        op_reg_src = 1'b1; // [RL3]
      end
      OISA_OP_LOGICAL_LEFT_SHIFT: begin
        op_ok = 1'b1;
        op_reg_src = 1'b1; // [RL5]
      end
      OISA_OP_LOGICAL_RIGHT_SHIFT: begin
        op_ok = 1'b1;
        op_reg_src = 1'b1; // [RL6]
      end
      default: begin
        op_ok = 1'b0;
        op_acc_only = 1'b0;
        op_reg_src = 1'b0;
      end
    endcase
  end

  // Flags each op may change; any flag not named keeps its value
  always_comb begin
    hit_zero = 1'b0;
    hit_carry = 1'b0;
    case (op_code)
      OISA_OP_OR_IMMEDIATE_INTO_ACC: begin
        hit_zero = 1'b1; // [RL1]
        hit_carry = 1'b0; // [RL8]
      end
      OISA_OP_REGISTER_INCREMENT: begin
        hit_zero = 1'b1; // [RL2]
        hit_carry = 1'b0; // [RL8]
      end
      OISA_OP_OR_ACC_WITH_REGISTER: begin
        hit_zero = 1'b1; // [RL3]
        hit_carry = 1'b0; // [RL8]
      end
      OISA_OP_LOGICAL_LEFT_SHIFT: begin
        hit_zero = 1'b1; // [RL5]
        hit_carry = 1'b1; // [RL5]
      end
      OISA_OP_LOGICAL_RIGHT_SHIFT: begin
        hit_zero = 1'b1; // [RL6]
        hit_carry = 1'b1; // [RL6]
      end
      default: begin
        hit_zero = 1'b0;
        hit_carry = 1'b0;
      end
    endcase
  end

  // Issue qualifier; or-immediate always lands in the accumulator
  assign issue = op_valid && op_ok;
  assign to_reg = issue && op_reg_src && (result_target_bit == OISA_DEST_REG); // [RL4]
  assign to_acc = issue && (op_acc_only ||
                            (op_reg_src && (result_target_bit == OISA_DEST_ACC))); // [RL4]

  ////////////////////////////////////////////////////////////////////////
  // Architectural state

  // Accumulator, written only when it is the destination
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_q <= DW'(OISA_ACC_RESET);
    end else if (to_acc) begin
      acc_q <= res; // [RL1] [RL4] [RL8]
    end
  end

  // Zero flag, named by every op here
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      null_result_flag <= OISA_ZERO_RESET;
    end else if (issue && hit_zero) begin
      null_result_flag <= res_zero; // [RL7]
    end
  end

  // Carry, held unless a shift names it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shift_out_bit <= OISA_CARRY_RESET;
    end else if (issue && hit_carry) begin
      shift_out_bit <= res_carry; // [RL5] [RL6] [RL8]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register write-back

  // Write strobe, a one-cycle pulse per register destination
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_wr_en <= 1'b0;
    end else begin
      reg_wr_en <= to_reg; // [RL4]
    end
  end

  // Write address, held until the next register write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_wr_addr <= '0;
    end else if (to_reg) begin
      reg_wr_addr <= register_operand_address; // [RL2] [RL3]
    end
  end

  // Write data, held together with the address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_wr_data <= '0;
    end else if (to_reg) begin
      reg_wr_data <= res; // [RL4]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completion

  // One pulse per accepted op, so each op takes a single cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      op_done <= 1'b0;
    end else begin
      op_done <= issue; // [RL8]
    end
  end
endmodule // oisa_alu

// ### src/oisa_pkg.sv
/*
  Shared constants and types for the or/increment/shift execution slice.
  Assumes a single instruction-cycle clock and an active-low async reset.
*/
package oisa_pkg;
  localparam int OISA_DATA_W = 8;
  localparam int OISA_ADDR_W = 7;
  localparam logic [7:0] OISA_ACC_RESET = 8'h00;
  localparam logic OISA_ZERO_RESET = 1'b0;
  localparam logic OISA_CARRY_RESET = 1'b0;
  localparam logic [7:0] OISA_ONE = 8'h01;
  localparam logic OISA_DEST_ACC = 1'b0;
  localparam logic OISA_DEST_REG = 1'b1;
  // Operation selector coming from the decoder
  typedef enum logic [2:0] {
    OISA_OP_NONE,
    OISA_OP_OR_IMMEDIATE_INTO_ACC,
    OISA_OP_REGISTER_INCREMENT,
    OISA_OP_OR_ACC_WITH_REGISTER,
    OISA_OP_LOGICAL_LEFT_SHIFT,
    OISA_OP_LOGICAL_RIGHT_SHIFT
  } oisa_op_t;
endpackage

// ### src/oisa_op_unit.sv
/*
  Combinational result unit: computes the result byte, zero indication
  and shift-out bit for one operation. Assumes operands are stable.
*/
`timescale 1ns/100ps
module oisa_op_unit #(
  parameter int DW = 8
) (
  // Operation and operands
  input wire oisa_pkg::oisa_op_t op,
  input wire logic [DW-1:0] acc_val,
  input wire logic [DW-1:0] reg_val,
  input wire logic [DW-1:0] imm_val,
  // Results
  output logic [DW-1:0] result,
  output logic is_zero,
  output logic shift_out
);
  import oisa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Result selection per operation
  always_comb begin
    result = '0;
    shift_out = 1'b0;
    case (op)
      OISA_OP_OR_IMMEDIATE_INTO_ACC: result = acc_val | imm_val; // [RL1]
      OISA_OP_REGISTER_INCREMENT: result = reg_val + DW'(OISA_ONE); // [RL2]
      OISA_OP_OR_ACC_WITH_REGISTER: result = acc_val | reg_val; // [RL3]
      OISA_OP_LOGICAL_LEFT_SHIFT: begin
        result = {reg_val[DW-2:0], 1'b0}; // [RL5]
        shift_out = reg_val[DW-1]; // [RL5]
      end
      OISA_OP_LOGICAL_RIGHT_SHIFT: begin
        result = {1'b0, reg_val[DW-1:1]}; // [RL6]
        shift_out = reg_val[0]; // [RL6]
      end
      default: result = '0;
    endcase
  end

  // All-zero detect
  assign is_zero = (result == '0); // [RL7]
endmodule // oisa_op_unit

// ### sim/oisa_alu_properties.sv
/* Port checker for oisa_alu. Assumes a bind onto the top module. */
`timescale 1ns/100ps
module oisa_alu_properties
  import oisa_pkg::*;
(
  input logic clk_sys, rstn, op_valid, result_target_bit, reg_wr_en,
  input oisa_op_t op_code,
  input logic [7:0] immediate_literal, reg_rd_data, reg_wr_data, acc_q,
  input logic [6:0] register_operand_address, reg_wr_addr,
  input logic null_result_flag, shift_out_bit, op_done
);
  logic go, ori, shl, shr;
  logic [7:0] res;
  logic [8:0] lsl, lsr;
  // Issue decode and expected shift images
  assign go = op_valid && op_code != OISA_OP_NONE && op_code <= OISA_OP_LOGICAL_RIGHT_SHIFT;
  assign ori = go && op_code == OISA_OP_OR_IMMEDIATE_INTO_ACC;
  assign shl = go && op_code == OISA_OP_LOGICAL_LEFT_SHIFT;
  assign shr = go && op_code == OISA_OP_LOGICAL_RIGHT_SHIFT;
  assign res = reg_wr_en ? reg_wr_data : acc_q;
  assign lsl = {reg_rd_data, 1'h0};
  assign lsr = {reg_rd_data[0], 1'h0, reg_rd_data[7:1]};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_ori; ori |=> acc_q == ($past(acc_q) | $past(immediate_literal)); endproperty
  a_ori: assert property (p_ori) else $error("or-immediate result");
  property p_inc; go && op_code == OISA_OP_REGISTER_INCREMENT && result_target_bit
    |=> reg_wr_data == $past(reg_rd_data) + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("increment result");
  property p_orr; go && op_code == OISA_OP_OR_ACC_WITH_REGISTER && !result_target_bit
    |=> acc_q == ($past(acc_q) | $past(reg_rd_data)); endproperty
  a_orr: assert property (p_orr) else $error("or-register result");
  property p_dst; go |=> reg_wr_en == ($past(result_target_bit) && !$past(ori)); endproperty
  a_dst: assert property (p_dst) else $error("destination steer");
  property p_wa; go && !ori && result_target_bit
    |=> reg_wr_addr == $past(register_operand_address); endproperty
  a_wa: assert property (p_wa) else $error("write-back address");
  property p_shl; shl |=> {shift_out_bit, res} == $past(lsl); endproperty
  a_shl: assert property (p_shl) else $error("left shift");
  property p_shr; shr |=> {shift_out_bit, res} == $past(lsr); endproperty
  a_shr: assert property (p_shr) else $error("right shift");
  property p_z; go |=> null_result_flag == (res == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag");
  property p_c; go && !shl && !shr |=> $stable(shift_out_bit) && op_done; endproperty
  a_c: assert property (p_c) else $error("carry kept or no done");
  property p_idle; !go |=> !op_done && !reg_wr_en && $stable(acc_q); endproperty
  a_idle: assert property (p_idle) else $error("idle changed state");
endmodule // oisa_alu_properties

// ### sim/oisa_regfile_model.sv
/* Register file model. Assumes reads are combinational. */
`timescale 1ns/100ps
module oisa_regfile_model (
  input logic clk_sys, wr_en,
  input logic [6:0] rd_addr, wr_addr,
  input logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  logic [7:0] mem [128];
  // Read addressed byte, write back on pulse
  assign rd_data = mem[rd_addr];
  always @(posedge clk_sys) if (wr_en) mem[wr_addr] <= wr_data;
endmodule // oisa_regfile_model

// ### sim/oisa_alu_test.sv
/* Bench for oisa_alu. Assumes the register file model. */
`timescale 1ns/100ps
module oisa_alu_test;
  import oisa_pkg::*;
  logic clk_sys = 1'h0, rstn = 1'h0, op_valid = 1'h0, tgt = 1'h0;
  oisa_op_t op_code = OISA_OP_NONE;
  logic [7:0] imm = 8'h00, rd, wd, acc;
  logic [6:0] addr = 7'h00, wa;
  logic we, z, c, done;
  int fails, compares;
  oisa_alu dut_u (.clk_sys, .rstn, .op_valid, .op_code, .immediate_literal(imm),
    .register_operand_address(addr), .result_target_bit(tgt), .reg_rd_data(rd),
    .reg_wr_en(we), .reg_wr_addr(wa), .reg_wr_data(wd), .acc_q(acc),
    .null_result_flag(z), .shift_out_bit(c), .op_done(done));
  oisa_regfile_model rf_u (.clk_sys, .wr_en(we), .rd_addr(addr), .wr_addr(wa),
    .wr_data(wd), .rd_data(rd));
  task automatic chk(string n, logic [8:0] s, logic [8:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // One op issued for one cycle, results seen a cycle later
  task automatic run(oisa_op_t o, logic [7:0] k, logic [6:0] a, logic t);
    @(negedge clk_sys);
    op_valid = 1'h1;
    op_code = o;
    imm = k;
    addr = a;
    tgt = t;
    @(negedge clk_sys);
    op_valid = 1'h0;
    chk("done", {8'h00, done}, 9'h001);
  endtask
  task automatic t_or;
    run(OISA_OP_OR_IMMEDIATE_INTO_ACC, 8'h00, 7'h05, 1'h1);
    chk("zero", {acc, z}, 9'h001);
    run(OISA_OP_OR_IMMEDIATE_INTO_ACC, 8'hA5, 7'h05, 1'h1);
    chk("ori", {we, acc}, 9'h0A5);
  endtask
  task automatic t_inc;
    rf_u.mem[5] = 8'hFF;
    rf_u.mem[127] = 8'h7F;
    run(OISA_OP_REGISTER_INCREMENT, 8'h00, 7'h05, 1'h1);
    chk("inc", {we, wd}, 9'h100);
    chk("inc_addr", {2'h0, wa}, 9'h005);
    chk("inc_acc", {acc, z}, 9'h14B);
    run(OISA_OP_REGISTER_INCREMENT, 8'h00, 7'h7F, 1'h0);
    chk("inc_w", {we, acc}, 9'h080);
  endtask
  task automatic t_orr;
    rf_u.mem[0] = 8'h01;
    run(OISA_OP_OR_ACC_WITH_REGISTER, 8'h00, 7'h00, 1'h1);
    chk("orr", {acc[7], wd}, 9'h181);
    run(OISA_OP_OR_ACC_WITH_REGISTER, 8'h00, 7'h00, 1'h0);
    chk("orr_acc", {we, acc}, 9'h081);
  endtask
  task automatic t_shift;
    rf_u.mem[9] = 8'h81;
    rf_u.mem[10] = 8'h01;
    run(OISA_OP_LOGICAL_LEFT_SHIFT, 8'h00, 7'h09, 1'h0);
    chk("lsl", {c, acc}, 9'h102);
    run(OISA_OP_LOGICAL_RIGHT_SHIFT, 8'h00, 7'h09, 1'h1);
    chk("lsr", {c, wd}, 9'h140);
    run(OISA_OP_LOGICAL_LEFT_SHIFT, 8'h00, 7'h09, 1'h1);
    chk("lsl0", {c, wd}, 9'h080);
    run(OISA_OP_LOGICAL_RIGHT_SHIFT, 8'h00, 7'h0A, 1'h0);
    chk("lsr_z", {c, z}, 9'h003);
    run(OISA_OP_OR_IMMEDIATE_INTO_ACC, 8'h00, 7'h0A, 1'h0);
    chk("keep_c", {c, z}, 9'h003);
  endtask
  // Mid-run reset clears state, then the first op works
  task automatic t_reset;
    @(negedge clk_sys);
    rstn = 1'h0;
    @(negedge clk_sys);
    chk("rst_acc", {done, acc}, 9'h000);
    chk("rst_flags", {7'h00, c, z}, 9'h000);
    chk("rst_wr", {we, wd}, 9'h000);
    chk("rst_wa", {2'h0, wa}, 9'h000);
    rstn = 1'h1;
    run(OISA_OP_OR_IMMEDIATE_INTO_ACC, 8'h3C, 7'h00, 1'h0);
    chk("rst_first", {z, acc}, 9'h03C);
  endtask
  // Op none and an unlisted code leave all state alone
  task automatic t_refuse;
    @(negedge clk_sys);
    op_valid = 1'h1;
    op_code = OISA_OP_NONE;
    @(negedge clk_sys);
    chk("none", {done, acc}, 9'h03C);
    op_code = oisa_op_t'(3'h6);
    @(negedge clk_sys);
    op_valid = 1'h0;
    chk("bad_done", {8'h00, done}, 9'h000);
    chk("bad_op", {z, acc}, 9'h03C);
  endtask
  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #12.5 clk_sys = ~clk_sys;
  initial begin
    repeat (8) @(negedge clk_sys);
    rstn = 1'h1;
    t_or;
    t_inc;
    t_orr;
    t_shift;
    t_reset;
    t_refuse;
    final_report;
  end
endmodule // oisa_alu_test
bind oisa_alu oisa_alu_properties chk_u (.clk_sys, .rstn, .op_valid, .result_target_bit,
  .reg_wr_en, .op_code, .immediate_literal, .reg_rd_data, .reg_wr_data, .acc_q,
  .null_result_flag, .shift_out_bit, .op_done, .register_operand_address, .reg_wr_addr);
